// ==== lts_pkg.sv ====
// Shared constants and types for the line thermal replica.
// Assumes a single 50 MHz APB clock; offsets are byte addresses, except the curve page, which is paddr[11:6].
package lts_pkg;
  // Timing
  localparam int CLK_MHZ = 50;
  localparam int STEP_US = 5000;
  localparam int CYCLE_TICKS = CLK_MHZ * STEP_US;
  localparam int TAU_UNITS_PER_MIN = 10;
  localparam int STEPS_PER_TAU_UNIT = 60 * 1000000 / (TAU_UNITS_PER_MIN * STEP_US);

  // Number formats
  localparam int NUM_W = 56;
  localparam int DEN_W = 48;
  localparam int RATIO_SHIFT = 38;
  localparam logic [15:0] K_ONE = 16'h4000;
  localparam int CURVE_PTS_MAX = 10;

  // Register offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_NOMINAL = 12'h004;
  localparam logic [11:0] OFS_SERVICE = 12'h008;
  localparam logic [11:0] OFS_TAU = 12'h00c;
  localparam logic [11:0] OFS_MIN_TEMP = 12'h010;
  localparam logic [11:0] OFS_REF_TEMP = 12'h014;
  localparam logic [11:0] OFS_MAX_TEMP = 12'h018;
  localparam logic [11:0] OFS_KLIM = 12'h01c;
  localparam logic [11:0] OFS_AMB_SET = 12'h020;
  localparam logic [11:0] OFS_STAT_THERM = 12'h024;
  localparam logic [11:0] OFS_STAT_LOAD = 12'h028;
  localparam logic [11:0] OFS_STAT_AMB = 12'h02c;
  localparam logic [5:0] OFS_CURVE_PAGE = 6'h01;

  // Control fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SRC_BIT = 1;
  localparam int CTRL_UNIT_BIT = 2;
  localparam int CTRL_CURVE_BIT = 3;
  localparam int CTRL_CNT_LSB = 4;
  localparam int CTRL_CLR_BIT = 8;

  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h21;
  localparam logic [15:0] RST_NOMINAL = 16'h0100;
  localparam logic [15:0] RST_SERVICE = 16'h0100;
  localparam logic [15:0] RST_TAU = 16'h0064;
  localparam logic [15:0] RST_MIN_TEMP = 16'hffce;
  localparam logic [15:0] RST_REF_TEMP = 16'h0096;
  localparam logic [15:0] RST_MAX_TEMP = 16'h01c2;
  localparam logic [15:0] RST_LOW_FACTOR = 16'h4852;
  localparam logic [15:0] RST_HIGH_FACTOR = 16'h3147;
  localparam logic [15:0] RST_AMB_SET = 16'h0096;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_XDIV = 5'b00010,
    ST_KDIV = 5'b00100,
    ST_RGO = 5'b01000,
    ST_RDIV = 5'b10000
  } lts_state_t;
endpackage

// ==== lts_div_if.sv ====
// Request and answer wires between the replica and its shared divider.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface lts_div_if #(
  parameter int NW = 56,
  parameter int DW = 48
);
  logic start;
  logic [NW-1:0] num;
  logic [DW-1:0] den;
  logic done;
  logic [NW-1:0] quot;
  modport client (output start, output num, output den, input done, input quot);
  modport server (input start, input num, input den, output done, output quot);
endinterface

// ==== lts_divider.sv ====
// Unsigned restoring divider, one quotient bit per clock.
// Assumes start is a one-cycle pulse with num and den valid alongside.
`timescale 1ns/1ps
module lts_divider #(
  parameter int NW = 56,
  parameter int DW = 48
) (
  input wire logic pclk,
  input wire logic presetn,
  lts_div_if.server div
);
  localparam int CW = $clog2(NW + 1);
  logic [DW:0] rem;
  logic [NW-1:0] quo;
  logic [DW-1:0] den_q;
  logic [CW-1:0] cnt;
  logic busy;
  logic done_q;

  // Divide by zero gives all ones, which callers treat as saturation
  wire [DW:0] rem_sh = {rem[DW-1:0], quo[NW-1]};
  wire fits = rem_sh >= {1'b0, den_q};
  wire [DW:0] rem_sub = rem_sh - {1'b0, den_q};
  wire last = busy && (cnt == CW'(1));

  // Shift loop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem <= '0;
      quo <= '0;
      den_q <= '0;
      cnt <= '0;
      busy <= 1'b0;
    end else if (div.start) begin
      rem <= '0;
      quo <= div.num;
      den_q <= div.den;
      cnt <= CW'(NW);
      busy <= 1'b1;
    end else if (busy) begin
      rem <= fits ? rem_sub : rem_sh;
      quo <= {quo[NW-2:0], fits};
      cnt <= cnt - CW'(1);
      busy <= !last;
    end
  end

  // Done pulse one cycle after the last step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
    end else begin
      done_q <= last;
    end
  end

  assign div.done = done_q;
  assign div.quot = quo;
endmodule // lts_divider

// ==== lts_line_thermal_replica.sv ====
// Thermal image of a cable, line or single time constant object.
// Assumes phase currents and sensor temperature come from logic on pclk.
// Notes on behaviour
// - Recompute image every fixed 5 ms cycle
// - Inputs are true-RMS currents incl. harmonics
// - Use largest of three phase currents
// - Exponential update toward squared load ratio, percent
// - Step 0.005 s, tau set in minutes; here tau is set in tenths of a minute
// - Service factor scales ratio denominator
// - Nominal load: 63% at tau, never above 100%
// - Zero current decays along same exponential
// - Three-point piecewise linear ambient factor
// - Ambient from sensor or manual setting
// - Temperatures in Celsius or Fahrenheit consistently
// - Reference temperature defaults to 15 degrees C
// - Optional ten-point interpolated correction curve
// - Curve works from two points upward
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module lts_line_thermal_replica
  import lts_pkg::*;
#(
  parameter int TICK_CYCLES = CYCLE_TICKS,
  parameter int CURVE_PTS = CURVE_PTS_MAX
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] true_rms_a,
  input wire logic [15:0] true_rms_b,
  input wire logic [15:0] true_rms_c,
  input wire logic [15:0] sensor_temp,
  input wire logic sensor_valid,
  output logic [23:0] thermal_percent,
  output logic [15:0] largest_phase_current,
  output logic [15:0] ambient_correction_factor,
  output logic update_done
);
  localparam int TW = $clog2(TICK_CYCLES);

  // Celsius tenths to Fahrenheit tenths, divide by 5 via reciprocal
  function automatic logic [15:0] c_to_f(input logic [15:0] c);
    logic signed [31:0] p;
    p = 32'(signed'(c)) * 32'sd9 * 32'sd26215;
    return 16'((p >>> 17) + 32'sd320);
  endfunction

  // Thermal fraction Q8.32 to percent with 8 fraction bits
  function automatic logic [23:0] to_percent(input logic [39:0] th);
    logic [31:0] p;
    p = 32'(th[39:16]) * 32'd100;
    return p[31:8];
  endfunction

  // Settings
  logic [7:0] ctrl;
  logic [15:0] nominal_current, service_factor, tau_setting;
  logic [15:0] minimum_temperature, reference_temperature, maximum_temperature;
  logic [15:0] low_end_factor, high_end_factor, ambient_setting;
  logic [31:0] curve [CURVE_PTS];

  // Working state
  lts_state_t state, next_state;
  logic [TW-1:0] tick_cnt;
  logic [39:0] theta;
  logic [31:0] x_step;
  logic [15:0] amb_factor, t_amb_cur, sensor_q, peak_current;
  logic [NUM_W-1:0] div_num;
  logic [DEN_W-1:0] div_den;
  logic div_start;

  lts_div_if #(.NW(NUM_W), .DW(DEN_W)) div_bus ();
  assign div_bus.start = div_start;
  assign div_bus.num = div_num;
  assign div_bus.den = div_den;

  lts_divider #(.NW(NUM_W), .DW(DEN_W)) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .div(div_bus)
  );

  // APB decode, zero wait states
  wire wr_en = psel && penable && pwrite;
  wire curve_hit = (paddr[11:6] == OFS_CURVE_PAGE) && (32'(paddr[5:2]) < CURVE_PTS);
  wire [3:0] curve_idx = paddr[5:2];
  wire fixed_hit = (paddr[11:6] == 6'h00) && (paddr[5:2] <= 4'hb) && (paddr[1:0] == 2'b00);
  wire addr_hit = fixed_hit || (curve_hit && paddr[1:0] == 2'b00);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;

  // Control fields
  wire run_en = ctrl[CTRL_EN_BIT];
  wire use_sensor = ctrl[CTRL_SRC_BIT];
  wire unit_f = ctrl[CTRL_UNIT_BIT];
  wire use_curve = ctrl[CTRL_CURVE_BIT];
  wire [3:0] pt_cnt = ctrl[CTRL_CNT_LSB +: 4];
  wire clr_req = wr_en && (paddr == OFS_CTRL) && pwdata[CTRL_CLR_BIT];

  // Settings writes; the clear bit is a strobe, not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= RST_CTRL;
      nominal_current <= RST_NOMINAL;
      service_factor <= RST_SERVICE;
      tau_setting <= RST_TAU;
      minimum_temperature <= RST_MIN_TEMP;
      reference_temperature <= RST_REF_TEMP;
      maximum_temperature <= RST_MAX_TEMP;
      low_end_factor <= RST_LOW_FACTOR;
      high_end_factor <= RST_HIGH_FACTOR;
      ambient_setting <= RST_AMB_SET;
    end else if (wr_en) begin
      unique case (paddr)
        OFS_CTRL: ctrl <= pwdata[7:0];
        OFS_NOMINAL: nominal_current <= pwdata[15:0];
        OFS_SERVICE: service_factor <= pwdata[15:0];
        OFS_TAU: tau_setting <= pwdata[15:0];
        OFS_MIN_TEMP: minimum_temperature <= pwdata[15:0];
        OFS_REF_TEMP: reference_temperature <= pwdata[15:0];
        OFS_MAX_TEMP: maximum_temperature <= pwdata[15:0];
        OFS_KLIM: {high_end_factor, low_end_factor} <= pwdata;
        OFS_AMB_SET: ambient_setting <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Curve points: low half temperature, high half factor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < CURVE_PTS; i++) begin
        curve[i] <= '0;
      end
    end else if (wr_en && curve_hit) begin
      curve[curve_idx] <= pwdata;
    end
  end

  // Read mux
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    if (curve_hit) begin
      rd_word = curve[curve_idx];
    end else begin
      unique case (paddr)
        OFS_CTRL: rd_word = {24'h00_0000, ctrl};
        OFS_NOMINAL: rd_word = {16'h0000, nominal_current};
        OFS_SERVICE: rd_word = {16'h0000, service_factor};
        OFS_TAU: rd_word = {16'h0000, tau_setting};
        OFS_MIN_TEMP: rd_word = {16'h0000, minimum_temperature};
        OFS_REF_TEMP: rd_word = {16'h0000, reference_temperature};
        OFS_MAX_TEMP: rd_word = {16'h0000, maximum_temperature};
        OFS_KLIM: rd_word = {high_end_factor, low_end_factor};
        OFS_AMB_SET: rd_word = {16'h0000, ambient_setting};
        OFS_STAT_THERM: rd_word = {8'h00, thermal_percent};
        OFS_STAT_LOAD: rd_word = {ambient_correction_factor, largest_phase_current};
        OFS_STAT_AMB: rd_word = {15'h0000, state != ST_IDLE, t_amb_cur};
        default: rd_word = 32'h0000_0000;
      endcase
    end
  end
  assign prdata = (psel && !pwrite && addr_hit) ? rd_word : 32'h0000_0000;

  // Sensor is held between samples so a slow sensor still gives a value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sensor_q <= RST_AMB_SET;
    end else if (sensor_valid) begin
      sensor_q <= sensor_temp;
    end
  end

  // Sensor reports Celsius; settings follow the selected unit
  wire [15:0] sensor_unit = unit_f ? c_to_f(sensor_q) : sensor_q;
  wire [15:0] amb_in = use_sensor ? sensor_unit : ambient_setting;

  // Largest phase current
  wire [15:0] max_ab = (true_rms_a > true_rms_b) ? true_rms_a : true_rms_b;
  wire [15:0] max3 = (max_ab > true_rms_c) ? max_ab : true_rms_c;

  // Cycle tick; free running so cycles keep a fixed spacing
  wire tick = (tick_cnt == TW'(TICK_CYCLES - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick ? '0 : tick_cnt + TW'(1);
    end
  end

  // Effective break points: three-point line or user curve
  logic signed [15:0] pt_t [CURVE_PTS];
  logic [15:0] pt_k [CURVE_PTS];
  logic [3:0] n_pts;
  always_comb begin
    for (int i = 0; i < CURVE_PTS; i++) begin
      pt_t[i] = signed'(curve[i][15:0]);
      pt_k[i] = curve[i][31:16];
    end
    n_pts = pt_cnt;
    if (!use_curve) begin
      pt_t[0] = signed'(minimum_temperature);
      pt_k[0] = low_end_factor;
      pt_t[1] = signed'(reference_temperature);
      pt_k[1] = K_ONE;
      pt_t[2] = signed'(maximum_temperature);
      pt_k[2] = high_end_factor;
      n_pts = 4'd3;
    end else if (pt_cnt < 4'd2) begin
      n_pts = 4'd2;
    end else if (32'(pt_cnt) > CURVE_PTS) begin
      n_pts = 4'(CURVE_PTS);
    end
  end

  // Segment search; unused points beyond n_pts are never looked at
  logic [3:0] seg;
  always_comb begin
    seg = 4'd1;
    for (int i = CURVE_PTS - 1; i >= 1; i--) begin
      if (4'(i) < n_pts && signed'(t_amb_cur) < pt_t[i]) begin
        seg = 4'(i);
      end
    end
  end

  wire signed [15:0] t_cur = signed'(t_amb_cur);
  wire below = t_cur <= pt_t[0];
  wire above = t_cur >= pt_t[n_pts - 4'd1];
  wire seg_flat = below || above;
  wire [15:0] flat_k = below ? pt_k[0] : pt_k[n_pts - 4'd1];
  wire signed [15:0] seg_t0 = pt_t[seg - 4'd1];
  wire signed [15:0] seg_t1 = pt_t[seg];
  wire [15:0] seg_k0 = pt_k[seg - 4'd1];
  wire [15:0] seg_k1 = pt_k[seg];
  wire signed [16:0] dk = 17'(signed'({1'b0, seg_k1})) - 17'(signed'({1'b0, seg_k0}));
  wire dk_neg = dk[16];
  wire [16:0] dk_mag = dk_neg ? 17'(-dk) : 17'(dk);
  wire [16:0] dt_pos = 17'(17'(t_cur) - 17'(seg_t0));
  wire [16:0] dt_span = 17'(17'(seg_t1) - 17'(seg_t0));
  wire [33:0] k_num = dk_mag * dt_pos;
  wire [16:0] k_q = div_bus.quot[16:0];
  wire [15:0] k_interp = dk_neg ? 16'(seg_k0 - k_q[15:0]) : 16'(seg_k0 + k_q[15:0]);

  // Ratio denominator: nominal current x service factor x ambient factor
  wire [31:0] in_sf = nominal_current * service_factor;
  wire [DEN_W-1:0] ratio_den = in_sf * amb_factor;
  wire [31:0] tau_den = 32'(tau_setting) * 32'(STEPS_PER_TAU_UNIT);

  // Squared load ratio; saturates near sixteen times nominal
  wire ratio_ovf = |div_bus.quot[NUM_W-1:20];
  wire [19:0] ratio = ratio_ovf ? 20'hf_ffff : div_bus.quot[19:0];
  wire [39:0] target = ratio * ratio;

  // First-order step toward target: theta += (target - theta) * t/tau.
  // Flooring keeps theta on its own side of the target, never past it.
  wire signed [40:0] diff = signed'({1'b0, target}) - signed'({1'b0, theta});
  wire signed [73:0] prod = diff * signed'({1'b0, x_step});
  wire signed [73:0] step = prod >>> 32;
  wire [39:0] next_theta = 40'(theta + 40'(step[40:0]));

  // Sequencer: time constant step, ambient factor, ratio, update
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (tick && run_en) next_state = ST_XDIV;
      ST_XDIV: if (div_bus.done) next_state = seg_flat ? ST_RGO : ST_KDIV;
      ST_KDIV: if (div_bus.done) next_state = ST_RGO;
      ST_RGO: next_state = ST_RDIV;
      ST_RDIV: if (div_bus.done) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Divider launches
  wire go_x = (state == ST_IDLE) && tick && run_en;
  wire go_k = (state == ST_XDIV) && div_bus.done && !seg_flat;
  wire go_r = (state == ST_RGO);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_start <= 1'b0;
      div_num <= '0;
      div_den <= '0;
    end else begin
      div_start <= go_x || go_k || go_r;
      if (go_x) begin
        div_num <= NUM_W'(64'h1_0000_0000);
        div_den <= DEN_W'(tau_den);
      end else if (go_k) begin
        div_num <= NUM_W'(k_num);
        div_den <= DEN_W'(dt_span);
      end else if (go_r) begin
        div_num <= {2'b00, peak_current, RATIO_SHIFT'(0)};
        div_den <= ratio_den;
      end
    end
  end

  // Cycle inputs are frozen at launch so one update sees one snapshot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t_amb_cur <= RST_AMB_SET;
      peak_current <= '0;
      x_step <= '0;
      amb_factor <= K_ONE;
    end else begin
      if (go_x) begin
        t_amb_cur <= amb_in;
        peak_current <= max3;
      end
      if (state == ST_XDIV && div_bus.done) begin
        x_step <= (|div_bus.quot[NUM_W-1:32]) ? 32'hffff_ffff : div_bus.quot[31:0];
        if (seg_flat) begin
          amb_factor <= flat_k;
        end
      end
      if (state == ST_KDIV && div_bus.done) begin
        amb_factor <= k_interp;
      end
    end
  end

  // Thermal memory; clear wins over an update in the same cycle
  wire upd = (state == ST_RDIV) && div_bus.done;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      theta <= '0;
    end else if (clr_req) begin
      theta <= '0;
    end else if (upd) begin
      theta <= next_theta;
    end
  end

  // Published results
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thermal_percent <= '0;
      largest_phase_current <= '0;
      ambient_correction_factor <= K_ONE;
      update_done <= 1'b0;
    end else begin
      update_done <= upd;
      if (clr_req) begin
        thermal_percent <= '0;
      end else if (upd) begin
        thermal_percent <= to_percent(next_theta);
      end
      if (upd) begin
        largest_phase_current <= peak_current;
        ambient_correction_factor <= amb_factor;
      end
    end
  end
endmodule // lts_line_thermal_replica

// ==== lts_replica_props.sv ====
// Concurrent checks on the top ports of the thermal replica.
// Assumes one pclk domain with active-low asynchronous presetn.
`timescale 1ns/1ps
module lts_replica_props
  import lts_pkg::*;
#(
  parameter int TICK_CYCLES = CYCLE_TICKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] true_rms_a,
  input wire logic [15:0] true_rms_b,
  input wire logic [15:0] true_rms_c,
  input wire logic [15:0] sensor_temp,
  input wire logic sensor_valid,
  input wire logic [23:0] thermal_percent,
  input wire logic [15:0] largest_phase_current,
  input wire logic [15:0] ambient_correction_factor,
  input wire logic update_done
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Control write in access phase; a clear moves the image without an update
  logic ctl_wr;
  assign ctl_wr = psel && penable && pwrite && (paddr == OFS_CTRL);

  // Fixed mapped aligned places up to 0x2c answer at once without error
  property p_ready;
    psel && penable && (paddr[11:6] == 6'h00) && (paddr[5:0] <= 6'h2c) &&
      (paddr[1:0] == 2'b00) |-> pready && !pslverr;
  endproperty
  a_ready: assert property (p_ready) else $error("mapped place refused");

  // One update per cycle; the gap is far longer than eight clocks
  property p_done_gap;
    update_done |=> !update_done [*8];
  endproperty
  a_done_gap: assert property (p_done_gap) else $error("update pulses too close");

  // Outputs only move together with an update; the image also moves on a clear
  property p_cur_done;
    $changed(largest_phase_current) |-> ##[0:1] update_done;
  endproperty
  a_cur_done: assert property (p_cur_done) else $error("current moved alone");

  property p_amb_done;
    $changed(ambient_correction_factor) |-> ##[0:1] update_done;
  endproperty
  a_amb_done: assert property (p_amb_done) else $error("factor moved alone");

  property p_pct_done;
    $changed(thermal_percent) && !$past(ctl_wr) && !$past(ctl_wr, 2) |-> ##[0:1] update_done;
  endproperty
  a_pct_done: assert property (p_pct_done) else $error("image moved alone");

  // Unmapped place refuses in its access phase
  property p_err_map;
    psel && penable && (paddr == 12'h100) |-> pslverr;
  endproperty
  a_err_map: assert property (p_err_map) else $error("no error on unmapped");

  property p_err_phase;
    pslverr |-> psel && penable;
  endproperty
  a_err_phase: assert property (p_err_phase) else $error("error outside access");

  // Read data stays quiet outside reads
  property p_rd_idle;
    !psel || pwrite |-> prdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
endmodule // lts_replica_props

bind lts_line_thermal_replica lts_replica_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .true_rms_a(true_rms_a), .true_rms_b(true_rms_b), .true_rms_c(true_rms_c),
  .sensor_temp(sensor_temp), .sensor_valid(sensor_valid), .thermal_percent(thermal_percent),
  .largest_phase_current(largest_phase_current),
  .ambient_correction_factor(ambient_correction_factor), .update_done(update_done)
);

// ==== lts_meter_model.sv ====
// Model of the phase current meters and the ambient temperature sensor.
// Assumes the bench sets the wanted levels; outputs move on pclk.
`timescale 1ns/1ps
module lts_meter_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] set_a,
  input wire logic [15:0] set_b,
  input wire logic [15:0] set_c,
  input wire logic [15:0] set_temp,
  output logic [15:0] true_rms_a,
  output logic [15:0] true_rms_b,
  output logic [15:0] true_rms_c,
  output logic [15:0] sensor_temp,
  output logic sensor_valid
);
  logic [3:0] slot;

  // Registered RMS stage; sensor valid one clock in sixteen, garbage between
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      true_rms_a <= 16'h0;
      true_rms_b <= 16'h0;
      true_rms_c <= 16'h0;
      sensor_temp <= 16'h0;
      sensor_valid <= 1'b0;
      slot <= 4'h0;
    end else begin
      true_rms_a <= set_a;
      true_rms_b <= set_b;
      true_rms_c <= set_c;
      slot <= slot + 4'h1;
      sensor_valid <= (slot == 4'hf);
      sensor_temp <= (slot == 4'hf) ? set_temp : ~sensor_temp; // Not a value to trust
    end
  end
endmodule // lts_meter_model

// ==== tb.sv ====
// Self-checking bench for the line thermal replica over APB.
// Assumes the meter model and the port checker bound in its own file.
`timescale 1ns/1ps
module tb;
  import lts_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, update_done, sensor_valid, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] true_rms_a, true_rms_b, true_rms_c, sensor_temp;
  logic [15:0] set_a, set_b, set_c, set_t, largest_phase_current, ambient_correction_factor;
  logic [23:0] thermal_percent;
  int n_mismatch, checked;
  // Load cases: phases, service factor, largest, image with zero time constant
  logic [15:0] ia [4] = '{16'h0100, 16'h0010, 16'h0020, 16'h0080};
  logic [15:0] ib [4] = '{16'h0020, 16'h0200, 16'h0010, 16'h0040};
  logic [15:0] ic [4] = '{16'h0010, 16'h0020, 16'h0100, 16'h0020};
  logic [15:0] sf [4] = '{16'h0100, 16'h0100, 16'h0200, 16'h0100};
  logic [15:0] mx [4] = '{16'h0100, 16'h0200, 16'h0100, 16'h0080};
  logic [23:0] pc [4] = '{24'h006400, 24'h019000, 24'h001900, 24'h001900};
  // Factor cases: control word, ambient, expected factor
  logic [7:0] cv [10] = '{8'h21, 8'h21, 8'h21, 8'h21, 8'h23, 8'h27, 8'h29, 8'h29, 8'h39, 8'h39};
  logic [15:0] at [10] = '{16'hff9c, 16'h0032, 16'h012c, 16'h0258, 16'hff9c,
                           16'h0000, 16'h0064, 16'h0258, 16'h012c, 16'hff9c};
  logic [15:0] kf [10] = '{16'h4852, 16'h4429, 16'h38a3, 16'h3147, 16'h4852,
                           16'h37a8, 16'h3000, 16'h2000, 16'h1800, 16'h4000};

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  lts_line_thermal_replica #(.TICK_CYCLES(400)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .true_rms_a(true_rms_a), .true_rms_b(true_rms_b), .true_rms_c(true_rms_c),
    .sensor_temp(sensor_temp), .sensor_valid(sensor_valid), .thermal_percent(thermal_percent),
    .largest_phase_current(largest_phase_current),
    .ambient_correction_factor(ambient_correction_factor), .update_done(update_done));

  lts_meter_model u_meter (
    .pclk(pclk), .presetn(presetn), .set_a(set_a), .set_b(set_b), .set_c(set_c),
    .set_temp(set_t), .true_rms_a(true_rms_a), .true_rms_b(true_rms_b),
    .true_rms_c(true_rms_c), .sensor_temp(sensor_temp), .sensor_valid(sensor_valid));

  task automatic give_verdict();
    if (n_mismatch == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
    checked++;
    if (((got + 32'(tol) >= exp) && (got <= exp + 32'(tol))) !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      n_mismatch++;
      give_verdict();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp, 0);
  endtask

  task automatic setcur(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    @(posedge pclk);
    set_a <= a;
    set_b <= b;
    set_c <= c;
  endtask

  // Waits out n update pulses, sampled mid-cycle; a missing pulse ends the run
  task automatic wait_upd(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      k = 0;
      do begin
        @(negedge pclk);
        k++;
      end while (update_done !== 1'b1 && k < 1000);
      if (k >= 1000) begin
        n_mismatch++;
        give_verdict();
      end
    end
  endtask

  initial begin
    n_mismatch = 0;
    checked = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    set_a = 16'h0;
    set_b = 16'h0;
    set_c = 16'h0;
    set_t = 16'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_CTRL, 32'h21);
    rd(OFS_REF_TEMP, 32'h96);
    rd(OFS_TAU, 32'h64);
    // Unmapped place answers with an error and no data
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, e}, 32'h1, 0);
    chk(r, 32'h0, 0);
    // Zero time constant lands straight on the squared ratio
    wr(OFS_TAU, 32'h0);
    for (int i = 0; i < 4; i++) begin
      setcur(ia[i], ib[i], ic[i]);
      wr(OFS_SERVICE, {16'h0, sf[i]});
      wait_upd(2);
      chk({16'h0, largest_phase_current}, {16'h0, mx[i]}, 0);
      chk({8'h0, thermal_percent}, {8'h0, pc[i]}, 1);
    end
    chk({16'h0, ambient_correction_factor}, 32'h4000, 0);
    // Nominal load holds the full image and does not climb past it
    setcur(16'h0100, 16'h0100, 16'h0100);
    wr(OFS_SERVICE, 32'h100);
    wait_upd(2);
    wr(OFS_TAU, 32'h1);
    wait_upd(3);
    chk({8'h0, thermal_percent}, 32'h6400, 1);
    // One cooling step with no current; the memory is kept
    setcur(16'h0, 16'h0, 16'h0);
    wait_upd(1);
    chk({8'h0, thermal_percent}, 32'h63ea, 2);
    // Clear, then one heating step of t over tau of the target
    wr(OFS_CTRL, 32'h121);
    wait_upd(1);
    chk({8'h0, thermal_percent}, 32'h0, 0);
    setcur(16'h0100, 16'h0100, 16'h0100);
    wait_upd(1);
    chk({8'h0, thermal_percent}, 32'h15, 2);
    // Disabled replica skips two ticks and keeps its memory
    wr(OFS_CTRL, 32'h20);
    repeat (900) @(posedge pclk);
    chk({8'h0, thermal_percent}, 32'h15, 2);
    // Curve points in ascending temperature; the third only counts with three
    wr(12'h040, 32'h4000_0000);
    wr(12'h044, 32'h2000_00c8);
    wr(12'h048, 32'h1000_0190);
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      set_t <= cv[i][1] ? at[i] : 16'h0096;
      wr(OFS_CTRL, {24'h0, cv[i]});
      wr(OFS_AMB_SET, cv[i][1] ? 32'h96 : {16'h0, at[i]});
      wait_upd(2);
      chk({16'h0, ambient_correction_factor}, {16'h0, kf[i]}, 3);
    end
    give_verdict();
  end
endmodule // tb
